// ---- hw/i2c_shift_pkg.sv ----
package i2c_shift_pkg;

    // ==========================================
    // Register offsets and reset values
    localparam logic [7:0] START_SAMPLE_SETUP_OFS = 8'hDB;
    localparam logic [7:0] SERIAL_DATA_SHIFT_OFS  = 8'hDE;
    localparam logic [7:0] OWN_SLAVE_ADDRESS_OFS  = 8'hDF;
    localparam logic [7:0] START_SAMPLE_SETUP_RST = 8'h00;
    localparam logic [7:0] SERIAL_DATA_SHIFT_RST  = 8'h00;
    localparam logic [7:0] OWN_SLAVE_ADDRESS_RST  = 8'h00;

    // ==========================================
    // Field positions
    localparam int SAMPLE_ENABLE_POS = 7;
    localparam int OWN_ADDR_LSB      = 1;
    localparam int OWN_ADDR_MSB      = 7;

    // ==========================================
    // Bus constants
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0] BITS_WITH_ACK   = 4'h9;
    localparam logic [6:0] GENERAL_CALL_ID = 7'h00;

    typedef struct packed {
        logic       sample_enable;
        logic [6:0] sample_count_field;
    } setup_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Snapshot of a finished byte, held stable while SCL is stalled
    typedef struct packed {
        logic       rx;
        logic       addr_hit;
        logic [7:0] byte_val;
    } byte_info_t;

    typedef enum logic [3:0] {
        LNK_IDLE     = 4'b0001,
        LNK_VALIDATE = 4'b0010,
        LNK_SHIFT    = 4'b0100,
        LNK_STALL    = 4'b1000
    } link_state_t;

endpackage : i2c_shift_pkg

// ---- hw/i2c_shift_addr_start_filter.sv ----
`timescale 1ns/1ns
// Function
// - Data register holds byte to send or byte received; a finished received byte loads it.
// - Bytes shift most significant bit first both ways, then the acknowledge bit.
// - Finished byte sets the completion flag and holds SCL low.
// - In transmit mode any data register write releases the SCL stall.
// - In receive mode a data register read releases the SCL stall.
// - Slave mode compares received address with own-address bits 7 to 1.
// - Seven-bit address match sets completion flag and address-match flag.
// - Own-address register is never written by hardware, ignored in master mode.
// - In slave mode SDA falling while SCL high starts a possible START.
// - Samples must see SDA low and SCL high before address reception begins.
// - A falling SDA edge failing validation is taken as START by the bus flags only, never by the shifter.
// - Sample enable clear gives exactly one sample one period after the edge.
// - Sample enable set gives count field plus one samples.
// - Validation samples are one oscillator period apart.
// - All three registers reset to zero, giving single-sample validation.
// - General-call flag sets on address zero, clears on START or STOP.
// - Bus-in-use flag sets on START and clears on STOP.
module i2c_shift_addr_start_filter
    import i2c_shift_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       link_clk,
    input  wire sfr_req_t   sfr_req,
    output logic      [7:0] sfr_rdata,
    input  wire logic       slave_mode,
    input  wire logic       tx_mode,
    input  wire logic       ack_enable,
    input  wire logic       intr_clear,
    input  wire logic       addr_match_clear,
    output logic            intr,
    output logic            addr_match,
    output logic            general_call_flag,
    output logic            bus_in_use_flag,
    output logic            ack_resp,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    // ==========================================
    // Register file (clk domain)
    setup_t      setup_q;
    logic [7:0]  data_q;
    logic [6:0]  own_q;
    logic [7:0]  rdata_q;
    logic        intr_q;
    logic        match_q;
    logic        stall_q;
    logic        rel_tgl_q;
    logic        done_m1_q, done_m2_q, done_p_q;
    logic        gc_m1_q, gc_m2_q;
    logic        busy_m1_q, busy_m2_q;
    logic        ackr_m1_q, ackr_m2_q;
    logic        done_ev;
    logic        data_wr, data_rd, release_now;

    // Link-side snapshot read here only after the done toggle has crossed
    byte_info_t  info_q;

    assign done_ev = done_m2_q ^ done_p_q;
    assign data_wr = sfr_req.wr && (sfr_req.addr == SERIAL_DATA_SHIFT_OFS);
    assign data_rd = sfr_req.rd && (sfr_req.addr == SERIAL_DATA_SHIFT_OFS);
    // Live mode decides: a read-bit address byte does not by itself select transmit mode
    assign release_now = stall_q && ((data_wr && tx_mode) || (data_rd && !tx_mode));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            setup_q <= setup_t'(START_SAMPLE_SETUP_RST);
            own_q   <= OWN_SLAVE_ADDRESS_RST[OWN_ADDR_MSB:OWN_ADDR_LSB];
        end else if (sfr_req.wr) begin
            if (sfr_req.addr == START_SAMPLE_SETUP_OFS) begin
                setup_q <= setup_t'(sfr_req.wdata);
            end
            // Only software ever writes the own address
            if (sfr_req.addr == OWN_SLAVE_ADDRESS_OFS) begin
                own_q <= sfr_req.wdata[OWN_ADDR_MSB:OWN_ADDR_LSB];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= SERIAL_DATA_SHIFT_RST;
        end else if (done_ev && info_q.rx) begin
            data_q <= info_q.byte_val;
        end else if (data_wr) begin
            data_q <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                START_SAMPLE_SETUP_OFS: rdata_q <= setup_q;
                SERIAL_DATA_SHIFT_OFS:  rdata_q <= data_q;
                OWN_SLAVE_ADDRESS_OFS:  rdata_q <= {own_q, 1'b0};
                default:                rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // Event flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intr_q  <= 1'b0;
            match_q <= 1'b0;
        end else begin
            if (done_ev) begin
                intr_q <= 1'b1;
            end else if (intr_clear) begin
                intr_q <= 1'b0;
            end
            if (done_ev && info_q.addr_hit) begin
                match_q <= 1'b1;
            end else if (addr_match_clear) begin
                match_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stall_q    <= 1'b0;
            rel_tgl_q  <= 1'b0;
        end else if (done_ev) begin
            stall_q    <= 1'b1;
        end else if (release_now) begin
            stall_q   <= 1'b0;
            rel_tgl_q <= ~rel_tgl_q;
        end
    end

    // ==========================================
    // Crossings into clk domain
    logic done_tgl_q, gc_q, busy_q, ackr_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_m1_q <= 1'b0;
            done_m2_q <= 1'b0;
            done_p_q  <= 1'b0;
            gc_m1_q   <= 1'b0;
            gc_m2_q   <= 1'b0;
            busy_m1_q <= 1'b0;
            busy_m2_q <= 1'b0;
            ackr_m1_q <= 1'b0;
            ackr_m2_q <= 1'b0;
        end else begin
            done_m1_q <= done_tgl_q;
            done_m2_q <= done_m1_q;
            done_p_q  <= done_m2_q;
            gc_m1_q   <= gc_q;
            gc_m2_q   <= gc_m1_q;
            busy_m1_q <= busy_q;
            busy_m2_q <= busy_m1_q;
            ackr_m1_q <= ackr_q;
            ackr_m2_q <= ackr_m1_q;
        end
    end

    assign sfr_rdata         = rdata_q;
    assign intr              = intr_q;
    assign addr_match        = match_q;
    assign general_call_flag = gc_m2_q;
    assign bus_in_use_flag   = busy_m2_q;
    assign ack_resp          = ackr_m2_q;

    // ==========================================
    // Link domain: reset, config and pin synchronisers
    // Config words are quasi-static; software changes them only while the bus is quiet
    logic        lrst_m1_q, lrst_n_q;
    logic [2:0]  ctl_m1_q, ctl_m2_q;
    logic [22:0] cfg_m1_q, cfg_m2_q;
    logic        rel_m1_q, rel_m2_q, rel_p_q;
    logic        scl_m1_q, scl_m2_q, scl_p_q;
    logic        sda_m1_q, sda_m2_q, sda_p_q;

    always_ff @(posedge link_clk) begin
        lrst_m1_q <= rst_n;
        lrst_n_q  <= lrst_m1_q;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n_q) begin
            ctl_m1_q <= 3'h0;
            ctl_m2_q <= 3'h0;
            cfg_m1_q <= 23'h000000;
            cfg_m2_q <= 23'h000000;
            rel_m1_q <= 1'b0;
            rel_m2_q <= 1'b0;
            rel_p_q  <= 1'b0;
            scl_m1_q <= 1'b1;
            scl_m2_q <= 1'b1;
            scl_p_q  <= 1'b1;
            sda_m1_q <= 1'b1;
            sda_m2_q <= 1'b1;
            sda_p_q  <= 1'b1;
        end else begin
            ctl_m1_q <= {slave_mode, tx_mode, ack_enable};
            ctl_m2_q <= ctl_m1_q;
            cfg_m1_q <= {setup_q, own_q, data_q};
            cfg_m2_q <= cfg_m1_q;
            rel_m1_q <= rel_tgl_q;
            rel_m2_q <= rel_m1_q;
            rel_p_q  <= rel_m2_q;
            scl_m1_q <= scl_i;
            scl_m2_q <= scl_m1_q;
            scl_p_q  <= scl_m2_q;
            sda_m1_q <= sda_i;
            sda_m2_q <= sda_m1_q;
            sda_p_q  <= sda_m2_q;
        end
    end

    logic       l_slave, l_tx, l_ack;
    setup_t     l_setup;
    logic [6:0] l_own;
    logic [7:0] l_data;
    logic       start_edge, stop_edge, scl_rise, scl_fall, rel_ev;

    assign {l_slave, l_tx, l_ack}  = ctl_m2_q;
    assign {l_setup, l_own, l_data} = cfg_m2_q;
    assign start_edge = scl_m2_q && scl_p_q && sda_p_q && !sda_m2_q;
    assign stop_edge  = scl_m2_q && scl_p_q && !sda_p_q && sda_m2_q;
    assign scl_rise   = scl_m2_q && !scl_p_q;
    assign scl_fall   = !scl_m2_q && scl_p_q;
    assign rel_ev     = rel_m2_q ^ rel_p_q;

    // ==========================================
    // Link domain: START filter and byte shifter
    link_state_t state_q;
    logic [6:0]  smp_cnt_q;
    logic [7:0]  shift_q;
    logic [3:0]  bit_cnt_q;
    logic        addr_phase_q;
    logic        sda_drv_q;
    logic        rx_eff;
    logic        own_hit, gc_hit;

    assign rx_eff  = addr_phase_q || !l_tx;
    assign own_hit = l_slave && (shift_q[7:1] == l_own);
    assign gc_hit  = l_slave && (shift_q[7:1] == GENERAL_CALL_ID);

    always_ff @(posedge link_clk) begin
        if (!lrst_n_q) begin
            state_q      <= LNK_IDLE;
            smp_cnt_q    <= 7'h00;
            shift_q      <= 8'h00;
            bit_cnt_q    <= 4'h0;
            addr_phase_q <= 1'b0;
            sda_drv_q    <= 1'b0;
            done_tgl_q   <= 1'b0;
            info_q       <= '0;
        end else if (stop_edge) begin
            state_q   <= LNK_IDLE;
            sda_drv_q <= 1'b0;
        end else if (start_edge && state_q != LNK_STALL) begin
            bit_cnt_q <= 4'h0;
            sda_drv_q <= 1'b0;
            if (l_slave) begin
                state_q   <= LNK_VALIDATE;
                smp_cnt_q <= l_setup.sample_enable ? l_setup.sample_count_field : 7'h00;
            end else begin
                state_q      <= LNK_SHIFT;
                addr_phase_q <= 1'b0;
                shift_q      <= l_data;
            end
        end else begin
            unique case (state_q)
                LNK_IDLE: begin
                    sda_drv_q <= 1'b0;
                end
                LNK_VALIDATE: begin
                    // One sample per link clock, the first one period after the edge
                    if (sda_m2_q || !scl_m2_q) begin
                        state_q <= LNK_IDLE;
                    end else if (smp_cnt_q == 7'h00) begin
                        state_q      <= LNK_SHIFT;
                        addr_phase_q <= 1'b1;
                        bit_cnt_q    <= 4'h0;
                    end else begin
                        smp_cnt_q <= smp_cnt_q - 7'h01;
                    end
                end
                LNK_SHIFT: begin
                    if (scl_rise) begin
                        if (bit_cnt_q < BITS_PER_BYTE) begin
                            shift_q <= {shift_q[6:0], sda_m2_q};
                        end
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == BITS_PER_BYTE) begin
                            // Acknowledge slot
                            if (addr_phase_q) begin
                                sda_drv_q <= l_ack && (own_hit || gc_hit);
                                if (!(own_hit || gc_hit)) begin
                                    state_q <= LNK_IDLE;
                                end
                            end else begin
                                sda_drv_q <= rx_eff && l_ack;
                            end
                        end else if (bit_cnt_q == BITS_WITH_ACK) begin
                            state_q          <= LNK_STALL;
                            sda_drv_q        <= 1'b0;
                            info_q.rx        <= rx_eff;
                            info_q.addr_hit  <= addr_phase_q && own_hit;
                            info_q.byte_val  <= shift_q;
                            done_tgl_q       <= ~done_tgl_q;
                        end else begin
                            sda_drv_q <= !rx_eff && !shift_q[7];
                        end
                    end
                end
                LNK_STALL: begin
                    // SCL is held low, so SDA may change here safely
                    if (rel_ev) begin
                        state_q      <= LNK_SHIFT;
                        addr_phase_q <= 1'b0;
                        bit_cnt_q    <= 4'h0;
                        shift_q      <= l_data;
                        sda_drv_q    <= l_tx && !l_data[7];
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Bus flags and acknowledge response
    always_ff @(posedge link_clk) begin
        if (!lrst_n_q) begin
            busy_q <= 1'b0;
            gc_q   <= 1'b0;
            ackr_q <= 1'b0;
        end else begin
            if (start_edge) begin
                busy_q <= 1'b1;
            end else if (stop_edge) begin
                busy_q <= 1'b0;
            end
            if (start_edge || stop_edge) begin
                gc_q <= 1'b0;
            end else if (state_q == LNK_SHIFT && scl_fall && bit_cnt_q == BITS_PER_BYTE
                         && addr_phase_q && gc_hit) begin
                gc_q <= 1'b1;
            end
            if (state_q == LNK_SHIFT && scl_rise && bit_cnt_q == BITS_PER_BYTE && !rx_eff) begin
                ackr_q <= sda_m2_q;
            end
        end
    end

    // Open-drain: only ever pull low
    assign scl_o  = 1'b0;
    assign scl_oe = (state_q == LNK_STALL);
    assign sda_o  = 1'b0;
    assign sda_oe = sda_drv_q && (state_q != LNK_IDLE);

endmodule : i2c_shift_addr_start_filter

// ---- verif/bus_host.sv ----
`timescale 1ns/1ns
module bus_host #(
    parameter int HALF = 1000
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull
);
    // ==========
    // Open-drain master: it only ever pulls low
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // The slave may stretch SCL; the wait is bounded so a stuck bus cannot hang
    task automatic scl_free();
        int n;
        n = 0;
        scl_pull = 1'b0;
        while (scl !== 1'b1 && n < 10000) begin
            #20;
            n++;
        end
    endtask : scl_free

    task automatic bit_cycle(input logic b, output logic s);
        sda_pull = !b;
        #(HALF / 2);
        scl_free();
        #(HALF / 2);
        s = sda;
        #(HALF / 2);
        scl_pull = 1'b1;
        #(HALF / 2);
    endtask : bit_cycle

    task automatic start_cond(input int hold);
        sda_pull = 1'b1;
        #hold;
        scl_pull = 1'b1;
        #(HALF / 2);
    endtask : start_cond

    task automatic stop_cond();
        sda_pull = 1'b1;
        #(HALF / 2);
        scl_free();
        #(HALF / 2);
        sda_pull = 1'b0;
        #HALF;
    endtask : stop_cond

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, ack);
    endtask : put_byte

    task automatic get_byte(input logic ack_out, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(ack_out, s);
    endtask : get_byte
endmodule : bus_host

// ---- verif/i2c_shift_addr_start_filter_asserts.sv ----
`timescale 1ns/1ns
module i2c_shift_addr_start_filter_asserts
    import i2c_shift_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire sfr_req_t   sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic       tx_mode,
    input wire logic       intr,
    input wire logic       addr_match,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_o
);
    logic dat_sel;
    assign dat_sel = sfr_req.addr == SERIAL_DATA_SHIFT_OFS;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Bus stall and release
    a_pins_open_drain: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    a_stall_sets_intr: assert property ($rose(scl_oe) |-> ##[1:10] intr)
        else $error("stall without intr");
    // Release crosses the link synchroniser into the link domain, hence the wide bound
    a_write_frees: assert property (sfr_req.wr && dat_sel && tx_mode && scl_oe |-> ##[1:48] !scl_oe)
        else $error("write kept stall");
    a_read_frees: assert property (sfr_req.rd && dat_sel && !tx_mode && scl_oe |-> ##[1:48] !scl_oe)
        else $error("read kept stall");
    a_match_with_intr: assert property ($rose(addr_match) |-> ##[0:8] intr)
        else $error("match without intr");

    // ==========
    // Register side
    a_rdata_holds: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata))
        else $error("read data moved");
    a_addr_lsb_zero: assert property ($past(sfr_req.rd) && $past(sfr_req.addr) == OWN_SLAVE_ADDRESS_OFS |-> !sfr_rdata[0])
        else $error("address bit 0 set");
    a_reset_clears: assert property ($rose(rst_n) |-> sfr_rdata == 8'h00 && !intr && !addr_match && !scl_oe)
        else $error("state after reset");
endmodule : i2c_shift_addr_start_filter_asserts

bind i2c_shift_addr_start_filter i2c_shift_addr_start_filter_asserts i2c_shift_addr_start_filter_asserts_i (
    .clk, .rst_n, .sfr_req, .sfr_rdata, .tx_mode, .intr, .addr_match, .scl_o, .scl_oe, .sda_o);

// ---- verif/test_i2c_shift_addr_start_filter.sv ----
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("FAIL %s expected %0h seen %0h", what, exp, got); end end

module test_i2c_shift_addr_start_filter;
    import i2c_shift_pkg::*;

    logic       clk, rst_n, link_clk, slave_mode, tx_mode, ack_enable;
    logic       intr_clear, addr_match_clear, intr, addr_match, ack;
    logic       general_call_flag, bus_in_use_flag, ack_resp;
    logic       scl_oe, sda_oe, scl_pull, sda_pull, scl_w, sda_w;
    logic [7:0] sfr_rdata, rd_val;
    sfr_req_t   sfr_req;
    int         miscompares, checks_done, cyc;

    // Pull-ups: the wire is low while anyone pulls it
    assign scl_w = !(scl_oe || scl_pull);
    assign sda_w = !(sda_oe || sda_pull);

    i2c_shift_addr_start_filter i2c_shift_addr_start_filter_i (
        .clk, .rst_n, .link_clk, .sfr_req, .sfr_rdata, .slave_mode, .tx_mode, .ack_enable,
        .intr_clear, .addr_match_clear, .intr, .addr_match, .general_call_flag, .bus_in_use_flag,
        .ack_resp, .scl_i(scl_w), .scl_o(), .scl_oe, .sda_i(sda_w), .sda_o(), .sda_oe);

    bus_host bus_host_i (.scl(scl_w), .sda(sda_w), .scl_pull, .sda_pull);

    always #10 clk = ~clk;

    // ==========
    // Register and service tasks
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) sfr_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk) sfr_req.wr <= 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) sfr_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk) sfr_req.rd <= 1'b0;
        @(negedge clk) d = sfr_rdata;
    endtask : sfr_rd

    // The extra cycles let the flags cross back from the link domain
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (scl_oe !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
    endtask : wait_oe

    task automatic pulse_clear();
        @(posedge clk);
        intr_clear <= 1'b1;
        addr_match_clear <= 1'b1;
        @(posedge clk);
        intr_clear <= 1'b0;
        addr_match_clear <= 1'b0;
    endtask : pulse_clear

    // ==========
    // Scenarios
    task automatic t_regs();
        logic [7:0] ofs [4] = '{START_SAMPLE_SETUP_OFS, SERIAL_DATA_SHIFT_OFS, OWN_SLAVE_ADDRESS_OFS, 8'hDC};
        foreach (ofs[i]) begin
            sfr_rd(ofs[i], rd_val);
            `CHK("reset read", 8'h00, rd_val)
        end
        sfr_wr(OWN_SLAVE_ADDRESS_OFS, 8'hFF);
        sfr_rd(OWN_SLAVE_ADDRESS_OFS, rd_val);
        `CHK("own address", 8'hFE, rd_val)
        sfr_wr(SERIAL_DATA_SHIFT_OFS, 8'h5A);
        sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
        `CHK("data reg", 8'h5A, rd_val)
        sfr_wr(OWN_SLAVE_ADDRESS_OFS, 8'hB4);
        sfr_wr(START_SAMPLE_SETUP_OFS, 8'h83);
        sfr_rd(START_SAMPLE_SETUP_OFS, rd_val);
        `CHK("setup reg", 8'h83, rd_val)
    endtask : t_regs

    task automatic t_rx();
        bus_host_i.start_cond(1000);
        bus_host_i.put_byte(8'hB4, ack);
        `CHK("address ack", 1'b0, ack)
        wait_oe(1'b1);
        `CHK("match flags", 2'b11, {intr, addr_match})
        `CHK("bus busy", 1'b1, bus_in_use_flag)
        sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
        `CHK("address byte", 8'hB4, rd_val)
        wait_oe(1'b0);
        `CHK("rx release", 1'b0, scl_oe)
        pulse_clear();
        bus_host_i.put_byte(8'hC5, ack);
        wait_oe(1'b1);
        `CHK("rx stall", 2'b11, {intr, scl_oe})
        sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
        `CHK("rx byte", 8'hC5, rd_val)
        wait_oe(1'b0);
        bus_host_i.stop_cond();
        repeat (20) @(posedge clk);
        `CHK("bus idle", 1'b0, bus_in_use_flag)
        sfr_rd(OWN_SLAVE_ADDRESS_OFS, rd_val);
        `CHK("own kept", 8'hB4, rd_val)
        pulse_clear();
    endtask : t_rx

    task automatic t_tx();
        bus_host_i.start_cond(1000);
        bus_host_i.put_byte(8'hB5, ack);
        wait_oe(1'b1);
        tx_mode <= 1'b1;
        sfr_wr(SERIAL_DATA_SHIFT_OFS, 8'hD2);
        wait_oe(1'b0);
        `CHK("tx release", 1'b0, scl_oe)
        bus_host_i.get_byte(1'b1, rd_val);
        `CHK("tx byte", 8'hD2, rd_val)
        wait_oe(1'b1);
        `CHK("no ack seen", 1'b1, ack_resp)
        // Dummy of all ones: after a refused byte SDA must stay free for the STOP
        sfr_wr(SERIAL_DATA_SHIFT_OFS, 8'hFF);
        wait_oe(1'b0);
        tx_mode <= 1'b0;
        bus_host_i.stop_cond();
        pulse_clear();
    endtask : t_tx

    // Hold of 1000 ns: 1 and 4 samples fit, 14 and 128 do not
    task automatic t_filter();
        logic [7:0] cfg [4] = '{8'h7F, 8'hFF, 8'h83, 8'h8D};
        logic       acc [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        foreach (cfg[i]) begin
            sfr_wr(START_SAMPLE_SETUP_OFS, cfg[i]);
            bus_host_i.start_cond(1000);
            bus_host_i.put_byte(8'hB4, ack);
            `CHK("start taken", !acc[i], ack)
            wait_oe(acc[i]);
            `CHK("filter intr", acc[i], intr)
            if (acc[i]) begin
                sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
                wait_oe(1'b0);
            end
            bus_host_i.stop_cond();
            pulse_clear();
        end
    endtask : t_filter

    task automatic t_gc();
        sfr_wr(START_SAMPLE_SETUP_OFS, 8'h00);
        bus_host_i.start_cond(1000);
        bus_host_i.put_byte(8'h00, ack);
        wait_oe(1'b1);
        `CHK("general call", 1'b1, general_call_flag)
        sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
        wait_oe(1'b0);
        bus_host_i.stop_cond();
        repeat (20) @(posedge clk);
        `CHK("general call off", 1'b0, general_call_flag)
        pulse_clear();
    endtask : t_gc

    // Master mode: the own address must play no part
    task automatic t_master();
        slave_mode <= 1'b0;
        repeat (10) @(posedge clk);
        bus_host_i.start_cond(1000);
        bus_host_i.put_byte(8'hB4, ack);
        wait_oe(1'b1);
        `CHK("master flags", 2'b10, {intr, addr_match})
        sfr_rd(SERIAL_DATA_SHIFT_OFS, rd_val);
        `CHK("master byte", 8'hB4, rd_val)
        wait_oe(1'b0);
        bus_host_i.stop_cond();
        slave_mode <= 1'b1;
        pulse_clear();
    endtask : t_master

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ==========
    // Run control
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sfr_req = '0;
        slave_mode = 1'b1;
        tx_mode = 1'b0;
        ack_enable = 1'b1;
        intr_clear = 1'b0;
        addr_match_clear = 1'b0;
        miscompares = 0;
        checks_done = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_rx();
        t_tx();
        t_filter();
        t_gc();
        t_master();
        stop_test();
    end
endmodule : test_i2c_shift_addr_start_filter
